// File: ram_block.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ram_block
	import ram_pkg::*;
#(
	parameter int BASE_W = 16,
	parameter int PAR_W = 2,
	parameter int DEPTH = 512,
	parameter int NP_KMAX = 4,
	parameter int P_KMAX = 1,
	parameter int SR_W = 4,
	parameter int SR_TAPS = 4,
	localparam int FW = BASE_W + PAR_W,
	localparam int WAW = $clog2(DEPTH),
	localparam int AAW = WAW + NP_KMAX
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic out_clr_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_ff,
	output logic pready_ff,
	output logic pslverr_ff,
	input wire logic [AAW-1:0] pa_addr,
	input wire logic [FW-1:0] pa_din,
	input wire logic pa_we,
	input wire logic pa_re,
	output logic [FW-1:0] pa_q_ff,
	input wire logic [AAW-1:0] pb_addr,
	input wire logic [FW-1:0] pb_din,
	input wire logic pb_we,
	input wire logic pb_re,
	output logic [FW-1:0] pb_q_ff,
	input wire logic sr_en,
	input wire logic [SR_W-1:0] sr_in,
	output logic [SR_W*SR_TAPS-1:0] sr_taps_ff,
	output logic [SR_W-1:0] sr_out_ff,
	output logic fifo_full_ff,
	output logic fifo_empty_ff
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// small or large block geometry
	if (!((BASE_W == 16 && PAR_W == 2 && DEPTH == 512 && NP_KMAX == 4 && P_KMAX == 1) ||
		(BASE_W == 32 && PAR_W == 4 && DEPTH == 4096 && NP_KMAX == 2 && P_KMAX == 2))) begin : g_bad_geom
		$error("unsupported block geometry");
	end
	if (SR_TAPS < 2 || SR_W * SR_TAPS > FW) begin : g_bad_sr
		$error("shift register lanes do not fit one word");
	end

	localparam logic [FW-1:0] SR_MASK = ~({FW{1'b1}} << (SR_W * SR_TAPS));
	localparam logic [WAW:0] FIFO_FULL = (WAW + 1)'(DEPTH);

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	logic [31:0] ctrl_ff;               // Control register
	logic [WAW-1:0] load_addr_ff;       // Preload word address
	logic [FW-1:0] load_data_ff;        // Preload word
	logic load_go_ff;                   // One-cycle preload write
	logic coll_ff;                      // Sticky write collision
	mode_t mode;
	logic rdw_new;
	logic [SRM_W-1:0] srm;
	logic cfg_err;
	logic coll_hit;
	logic commit;                       // APB access completes this edge
	logic [2:0] eff_k [2];              // Narrowing shift per port
	logic eff_par [2];                  // Parity family per port
	logic oreg [2];

	assign mode = mode_t'(ctrl_ff[C_MODE +: 2]);
	assign rdw_new = ctrl_ff[C_RDW_NEW];
	assign srm = ctrl_ff[C_SRM +: SRM_W];
	assign oreg[0] = ctrl_ff[C_OREG_A];
	assign oreg[1] = ctrl_ff[C_OREG_B];
	assign commit = psel && penable && pready_ff;

	// ----------------------------------------
	// Width decode and pairing check
	// ----------------------------------------
	always_comb begin
		logic [3:0] wc [2];
		wc[0] = ctrl_ff[C_WA +: 4];
		wc[1] = ctrl_ff[C_WB +: 4];
		cfg_err = (wc[0][WC_PAR] != wc[1][WC_PAR]);
		for (int p = 0; p < 2; p++) begin
			if (mode == MODE_TDP || mode == MODE_ROM) begin
				eff_k[p] = wc[p][2:0];
				eff_par[p] = wc[p][WC_PAR];
				// Narrowest width allowed per family
				if (32'(wc[p][2:0]) > (wc[p][WC_PAR] ? P_KMAX : NP_KMAX)) begin
					cfg_err = 1'b1;
				end
			end else begin
				eff_k[p] = 3'h0;
				eff_par[p] = 1'b1;
			end
		end
		if (mode == MODE_SHIFT) begin
			cfg_err = (srm < SR_M_MIN) || (32'(srm) > DEPTH);
		end else if (mode == MODE_FIFO) begin
			cfg_err = 1'b0;
		end
	end

	// ----------------------------------------
	// Per-port data paths
	// ----------------------------------------
	logic [AAW-1:0] u_addr [2];
	logic [FW-1:0] u_din [2];
	logic u_we [2];
	logic u_re [2];
	logic [WAW-1:0] d_waddr [2];        // Word address
	logic [FW-1:0] d_mask [2];          // Lane write mask
	logic [FW-1:0] d_din [2];           // Data placed in its lane
	logic [WAW-1:0] m_addr [2];         // Storage requests after mode steering
	logic m_we [2];
	logic m_re [2];
	logic [FW-1:0] m_mask [2];
	logic [FW-1:0] m_din [2];
	logic [FW-1:0] mq [2];              // Registered storage read data
	logic [FW-1:0] ext [2];             // Lane pulled out of read word
	logic re_d [2];
	logic [FW-1:0] q_arr [2];
	logic [FW-1:0] pa_ext;

	assign u_addr[0] = pa_addr;
	assign u_addr[1] = pb_addr;
	assign u_din[0] = pa_din;
	assign u_din[1] = pb_din;
	assign u_we[0] = pa_we;
	assign u_we[1] = pb_we;
	assign u_re[0] = pa_re;
	assign u_re[1] = pb_re;
	assign pa_q_ff = q_arr[0];
	assign pb_q_ff = q_arr[1];
	assign pa_ext = ext[0];

	for (genvar p = 0; p < 2; p++) begin : g_port
		logic [5:0] w;
		logic [5:0] sh;
		logic [FW-1:0] lm;
		logic [AAW-1:0] sel;
		logic [5:0] sh_d_ff;
		logic [FW-1:0] lm_d_ff;
		logic re_d_ff;
		logic [FW-1:0] s1_ff;
		logic [FW-1:0] q_ff;
		logic [FW-1:0] nxt_s1;

		// Lane position from the low address bits
		always_comb begin
			w = eff_par[p] ? 6'(FW >> eff_k[p]) : 6'(BASE_W >> eff_k[p]);
			sel = u_addr[p] & ~({AAW{1'b1}} << eff_k[p]);
			sh = 6'(32'(sel) * 32'(w));
			lm = ~({FW{1'b1}} << w);
			d_waddr[p] = WAW'(u_addr[p] >> eff_k[p]);
			d_mask[p] = lm << sh;
			d_din[p] = (u_din[p] & lm) << sh;
		end

		// Lane position follows its read by one cycle
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				re_d_ff <= 1'b0;
				sh_d_ff <= 6'h00;
				lm_d_ff <= '0;
			end else begin
				re_d_ff <= m_re[p];
				sh_d_ff <= sh;
				lm_d_ff <= lm;
			end
		end

		assign ext[p] = (mq[p] >> sh_d_ff) & lm_d_ff;
		assign re_d[p] = re_d_ff;
		assign nxt_s1 = re_d_ff ? ext[p] : s1_ff;

		// Output stage, cleared at once by the clear pin
		always_ff @(posedge mclk or negedge arst_n or negedge out_clr_n) begin
			if (!arst_n || !out_clr_n) begin
				s1_ff <= '0;
				q_ff <= '0;
			end else begin
				s1_ff <= nxt_s1;
				q_ff <= oreg[p] ? s1_ff : nxt_s1;
			end
		end
		assign q_arr[p] = q_ff;
	end

	// ----------------------------------------
	// Shift-register and FIFO state
	// ----------------------------------------
	logic [WAW-1:0] sr_ptr_ff;
	logic [WAW-1:0] sr_wptr_ff;
	logic sr_en_d_ff;
	logic [SR_W-1:0] sr_in_d_ff;
	logic [WAW-1:0] wr_ptr_ff;
	logic [WAW-1:0] rd_ptr_ff;
	logic [WAW:0] count_ff;
	logic [WAW:0] nxt_count;
	logic push;
	logic pop;
	logic sr_go;

	assign sr_go = sr_en && (mode == MODE_SHIFT) && !cfg_err;
	assign push = (mode == MODE_FIFO) && pb_we && !fifo_full_ff;
	assign pop = (mode == MODE_FIFO) && pa_re && !fifo_empty_ff;

	// ----------------------------------------
	// Storage request steering
	// ----------------------------------------
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			m_addr[p] = d_waddr[p];
			m_we[p] = u_we[p] && !cfg_err;
			m_re[p] = u_re[p];
			m_mask[p] = d_mask[p];
			m_din[p] = d_din[p];
		end
		case (mode)
			MODE_TDP: begin
			end
			MODE_ROM: begin
				m_we[0] = 1'b0;
				m_we[1] = 1'b0;
			end
			MODE_SHIFT: begin
				// read a slot, rewrite it shifted
				m_addr[0] = sr_ptr_ff;
				m_we[0] = 1'b0;
				m_re[0] = sr_go;
				m_addr[1] = sr_wptr_ff;
				m_we[1] = sr_en_d_ff;
				m_re[1] = 1'b0;
				m_mask[1] = SR_MASK;
				m_din[1] = FW'({mq[0][SR_W*(SR_TAPS-1)-1:0], sr_in_d_ff});
			end
			MODE_FIFO: begin
				// push on port B, pop on port A
				m_addr[0] = rd_ptr_ff;
				m_we[0] = 1'b0;
				m_re[0] = pop;
				m_addr[1] = wr_ptr_ff;
				m_we[1] = push;
				m_re[1] = 1'b0;
				m_mask[1] = '1;
			end
			default: begin
				m_we[0] = 1'b0;
				m_we[1] = 1'b0;
			end
		endcase
		if (load_go_ff) begin
			m_addr[0] = load_addr_ff;
			m_we[0] = 1'b1;
			m_re[0] = 1'b0;
			m_mask[0] = '1;
			m_din[0] = load_data_ff;
		end
	end

	// one shared clock for all stages
	// no second clock, so no undefined case
	ram_store #(.AW(WAW), .DW(FW)) u_store (
		.clk(mclk),
		.arst_n(arst_n),
		.new_data(rdw_new),
		.a_addr(m_addr[0]),
		.a_we(m_we[0]),
		.a_re(m_re[0]),
		.a_mask(m_mask[0]),
		.a_din(m_din[0]),
		.a_q_ff(mq[0]),
		.b_addr(m_addr[1]),
		.b_we(m_we[1]),
		.b_re(m_re[1]),
		.b_mask(m_mask[1]),
		.b_din(m_din[1]),
		.b_q_ff(mq[1])
	);

	// Shift pointer walks 0 .. m-1
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sr_ptr_ff <= '0;
			sr_wptr_ff <= '0;
			sr_en_d_ff <= 1'b0;
			sr_in_d_ff <= '0;
		end else begin
			sr_en_d_ff <= sr_go;
			sr_wptr_ff <= sr_ptr_ff;
			sr_in_d_ff <= sr_in;
			if (mode != MODE_SHIFT) begin
				sr_ptr_ff <= '0;
			end else if (sr_go) begin
				sr_ptr_ff <= (SRM_W'(sr_ptr_ff) + 13'h0001 >= srm) ? '0 : sr_ptr_ff + 1'b1;
			end
		end
	end

	// Tap outputs; the last lane feeds a following block
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sr_taps_ff <= '0;
			sr_out_ff <= '0;
		end else if (sr_en_d_ff) begin
			sr_taps_ff <= mq[0][SR_W*SR_TAPS-1:0];
			sr_out_ff <= mq[0][SR_W*(SR_TAPS-1) +: SR_W];
		end
	end

	always_comb begin
		nxt_count = count_ff + (WAW + 1)'(push) - (WAW + 1)'(pop);
	end

	// FIFO pointers and flags, emptied when leaving the mode
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			fifo_full_ff <= 1'b0;
			fifo_empty_ff <= 1'b1;
		end else if (mode != MODE_FIFO) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			fifo_full_ff <= 1'b0;
			fifo_empty_ff <= 1'b1;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + WAW'(push);
			rd_ptr_ff <= rd_ptr_ff + WAW'(pop);
			count_ff <= nxt_count;
			fifo_full_ff <= (nxt_count == FIFO_FULL);
			fifo_empty_ff <= (nxt_count == '0);
		end
	end

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	assign coll_hit = m_we[0] && m_we[1] && (m_addr[0] == m_addr[1]) && |(m_mask[0] & m_mask[1]);

	// Register writes and preload strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= CTRL_RESET;
			load_addr_ff <= '0;
			load_data_ff <= '0;
			load_go_ff <= 1'b0;
		end else begin
			load_go_ff <= commit && pwrite && (paddr == REG_LOAD_DATA);
			if (commit && pwrite) begin
				case (paddr)
					REG_CTRL: ctrl_ff <= pwdata;
					REG_LOAD_ADDR: load_addr_ff <= pwdata[WAW-1:0];
					REG_LOAD_DATA: load_data_ff <= pwdata[FW-1:0];
					default: begin
					end
				endcase
			end
		end
	end

	// Collision flag: a new hit beats a write-one clear
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			coll_ff <= 1'b0;
		end else begin
			coll_ff <= coll_hit || (coll_ff && !(commit && pwrite && paddr == REG_STATUS && pwdata[S_COLL]));
		end
	end

	// Answer: ready one cycle into the access phase
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pready_ff <= 1'b0;
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= psel && penable && !pready_ff;
			if (psel && penable && !pready_ff) begin
				prdata_ff <= '0;
				pslverr_ff <= 1'b0;
				case (paddr)
					REG_CTRL: prdata_ff <= ctrl_ff;
					REG_STATUS: begin
						prdata_ff[S_CFG_ERR] <= cfg_err;
						prdata_ff[S_COLL] <= coll_ff;
						prdata_ff[S_EMPTY] <= fifo_empty_ff;
						prdata_ff[S_FULL] <= fifo_full_ff;
						prdata_ff[S_COUNT +: WAW + 1] <= count_ff;
					end
					REG_LOAD_ADDR: prdata_ff[WAW-1:0] <= load_addr_ff;
					REG_LOAD_DATA: prdata_ff[FW-1:0] <= load_data_ff;
					default: pslverr_ff <= 1'b1;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	sequence rd_reg_s;
		oreg[0] && re_d[0] && out_clr_n ##1 oreg[0] && out_clr_n;
	endsequence

	out_hold_a: assert property (
		!re_d[0] && !oreg[0] && out_clr_n |=> $stable(pa_q_ff))
		else $error("port A output moved while idle");
	oreg_late_a: assert property (
		rd_reg_s |=> pa_q_ff == $past(pa_ext, 2))
		else $error("registered read not two edges late");
	unreg_lat_a: assert property (
		!oreg[0] && re_d[0] && out_clr_n |=> pa_q_ff == $past(pa_ext))
		else $error("unregistered read not one edge late");
	rom_nowr_a: assert property (
		mode == MODE_ROM && !load_go_ff |-> !m_we[0] && !m_we[1])
		else $error("write reached storage in ROM mode");
	pair_block_a: assert property (
		mode == MODE_TDP && ctrl_ff[C_WA + WC_PAR] != ctrl_ff[C_WB + WC_PAR] |-> cfg_err && !m_we[1])
		else $error("mixed width families not refused");
	clr_zero_a: assert property (
		!out_clr_n |-> pa_q_ff == '0 && pb_q_ff == '0)
		else $error("output not cleared");
	fifo_push_a: assert property (
		push && !pop |=> count_ff == $past(count_ff) + 1'b1 && !fifo_empty_ff)
		else $error("push did not raise fill level");
	fifo_full_a: assert property (
		fifo_full_ff && pb_we && !pa_re |=> fifo_full_ff && $stable(wr_ptr_ff))
		else $error("push accepted while full");

endmodule

`default_nettype wire

// File: ram_pkg.sv
`default_nettype none

package ram_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LOAD_ADDR = 8'h08;
	localparam logic [7:0] REG_LOAD_DATA = 8'h0C;

	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int C_MODE = 0;     // Two bits, operating mode
	localparam int C_RDW_NEW = 2;  // Same-port read-during-write shows new data
	localparam int C_OREG_A = 3;   // Output register on port A
	localparam int C_OREG_B = 4;   // Output register on port B
	localparam int C_WA = 5;       // Four bits, port A width code
	localparam int C_WB = 9;       // Four bits, port B width code
	localparam int C_SRM = 13;     // Tap spacing of the shift register
	localparam int SRM_W = 13;     // Width of the tap spacing field
	localparam int WC_PAR = 3;     // Width code bit: parity-width family
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int S_CFG_ERR = 0;  // Width pairing or spacing not allowed
	localparam int S_COLL = 1;     // Sticky: both ports wrote one word
	localparam int S_EMPTY = 2;
	localparam int S_FULL = 3;
	localparam int S_COUNT = 4;    // FIFO fill level

	// Least tap spacing the read-then-write pipeline can serve
	localparam logic [SRM_W-1:0] SR_M_MIN = 13'h0002;

	// Operating modes, Gray coded
	typedef enum logic [1:0] {
		MODE_TDP = 2'h0,
		MODE_SHIFT = 2'h1,
		MODE_ROM = 2'h3,
		MODE_FIFO = 2'h2
	} mode_t;

endpackage

`default_nettype wire

// File: ram_store.sv
`timescale 1ns/1ps
`default_nettype none

// Two-port storage array with bit write masks and registered read data
module ram_store #(
	parameter int AW = 9,
	parameter int DW = 18
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic new_data,
	input wire logic [AW-1:0] a_addr,
	input wire logic a_we,
	input wire logic a_re,
	input wire logic [DW-1:0] a_mask,
	input wire logic [DW-1:0] a_din,
	output logic [DW-1:0] a_q_ff,
	input wire logic [AW-1:0] b_addr,
	input wire logic b_we,
	input wire logic b_re,
	input wire logic [DW-1:0] b_mask,
	input wire logic [DW-1:0] b_din,
	output logic [DW-1:0] b_q_ff
);

	logic [DW-1:0] mem [2**AW];  // Storage cells, no reset
	logic [DW-1:0] cur_a;        // Word at port A address before the edge
	logic [DW-1:0] cur_b;        // Word at port B address before the edge

	assign cur_a = mem[a_addr];
	assign cur_b = mem[b_addr];

	// ----------------------------------------
	// Write side
	// ----------------------------------------
	// both ports write in one cycle
	always_ff @(posedge clk) begin
		for (int i = 0; i < DW; i++) begin
			if (a_we && a_mask[i]) begin
				mem[a_addr][i] <= a_din[i];
			end
			if (b_we && b_mask[i]) begin
				mem[b_addr][i] <= b_din[i];
			end
		end
	end

	// ----------------------------------------
	// Read side
	// ----------------------------------------
	// address taken at the edge
	// same-port write chooses new or old
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a_q_ff <= '0;
			b_q_ff <= '0;
		end else begin
			if (a_re) begin
				a_q_ff <= (a_we && new_data) ? ((cur_a & ~a_mask) | (a_din & a_mask)) : cur_a;
			end
			if (b_re) begin
				b_q_ff <= (b_we && new_data) ? ((cur_b & ~b_mask) | (b_din & b_mask)) : cur_b;
			end
		end
	end

	rdw_new_a: assert property (@(posedge clk) disable iff (!arst_n)
		a_re && a_we && new_data |=> a_q_ff === $past((cur_a & ~a_mask) | (a_din & a_mask)))
		else $error("new-data read during write wrong");
	rdw_old_a: assert property (@(posedge clk) disable iff (!arst_n)
		a_re && a_we && !new_data |=> a_q_ff === $past(cur_a))
		else $error("old-data read during write wrong");
	mix_old_a: assert property (@(posedge clk) disable iff (!arst_n)
		b_re && !b_we && a_we && (a_addr == b_addr) |=> b_q_ff === $past(cur_b))
		else $error("mixed-port read did not return old data");

endmodule

`default_nettype wire

// File: fabric_port.sv
`timescale 1ns/1ps
`default_nettype none

// Fabric-side driver of one RAM port
module fabric_port #(
	parameter int AW = 13,
	parameter int DW = 18
) (
	input wire logic mclk,
	output logic [AW-1:0] addr,
	output logic [DW-1:0] din,
	output logic we,
	output logic re
);
	// Quiet port at time zero
	initial begin
		addr = '0;
		din = '0;
		we = 1'b0;
		re = 1'b0;
	end
	task automatic go(input logic w, input logic r, input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge mclk);
		we <= w;
		re <= r;
		addr <= a;
		din <= d;
	endtask
	task automatic idle();
		@(posedge mclk);
		we <= 1'b0;
		re <= 1'b0;
		addr <= ~addr;
		din <= ~din;
	endtask
endmodule

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ram_pkg::*;
	logic mclk, arst_n, out_clr_n, psel, penable, pwrite, pready_ff, pslverr_ff, err, fe;
	logic pa_we, pa_re, pb_we, pb_re;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_ff, rdat;
	logic [12:0] pa_addr, pb_addr;
	logic [17:0] pa_din, pb_din, pa_q_ff, pb_q_ff;
	logic sr_en, fifo_full_ff;
	logic [3:0] sr_in, sr_out_ff;
	logic [15:0] sr_taps_ff;
	int mismatches, n_checks;
	ram_block dut (.mclk(mclk), .arst_n(arst_n), .out_clr_n(out_clr_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.pa_addr(pa_addr), .pa_din(pa_din), .pa_we(pa_we), .pa_re(pa_re), .pa_q_ff(pa_q_ff),
		.pb_addr(pb_addr), .pb_din(pb_din), .pb_we(pb_we), .pb_re(pb_re), .pb_q_ff(pb_q_ff),
		.sr_en(sr_en), .sr_in(sr_in), .sr_taps_ff(sr_taps_ff), .sr_out_ff(sr_out_ff), .fifo_full_ff(fifo_full_ff),
		.fifo_empty_ff(fe));
	fabric_port pa (.mclk(mclk), .addr(pa_addr), .din(pa_din), .we(pa_we), .re(pa_re));
	fabric_port pb (.mclk(mclk), .addr(pb_addr), .din(pb_din), .we(pb_we), .re(pb_re));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Hold the request until ready is seen at an edge; the watchdog ends a hang
		do begin
			@(posedge mclk);
		end while (pready_ff !== 1'b1);
		rdat = prdata_ff;
		err = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Write one element on a port
	task automatic wr(input logic p, input logic [12:0] a, input logic [17:0] d);
		if (p) pb.go(1'b1, 1'b0, a, d); else pa.go(1'b1, 1'b0, a, d);
		if (p) pb.idle(); else pa.idle();
	endtask
	// Read one element, check after lat edges
	task automatic rdq(input logic p, input logic [12:0] a, input logic [17:0] e, input int lat);
		if (p) pb.go(1'b0, 1'b1, a, '0); else pa.go(1'b0, 1'b1, a, '0);
		if (p) pb.idle(); else pa.idle();
		repeat (lat) @(posedge mclk);
		#1 chk(p ? pb_q_ff : pa_q_ff, e);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		apb(1'b0, REG_CTRL, 0);
		chk(rdat, CTRL_RESET);
		apb(1'b0, REG_STATUS, 0);
		chk(rdat, 32'h0000_0004);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		chk({rdat[30:0], err}, 32'h0000_0001);
	endtask
	task automatic t_dual();
		fork pa.go(1'b1, 1'b0, 13'h0007, 18'h0A5C3); pb.go(1'b1, 1'b0, 13'h0008, 18'h05A3C); join
		fork pa.idle(); pb.idle(); join
		fork rdq(1'b0, 13'h0008, 18'h05A3C, 1); rdq(1'b1, 13'h0007, 18'h0A5C3, 1); join
		fork pa.go(1'b1, 1'b0, 13'h0008, 18'h01234); pb.go(1'b0, 1'b1, 13'h0008, '0); join
		fork pa.idle(); pb.idle(); join
		@(posedge mclk);
		#1 chk(pb_q_ff, 18'h05A3C);
		rdq(1'b1, 13'h0008, 18'h01234, 1);
		wr(1'b0, 13'h0008, 18'h0BEEF);
		repeat (3) @(posedge mclk);
		#1 chk(pa_q_ff, 18'h05A3C);
	endtask
	task automatic t_rdw();
		apb(1'b1, REG_CTRL, 32'h0000_0004);
		pa.go(1'b1, 1'b1, 13'h0008, 18'h0CAFE);
		pa.idle();
		@(posedge mclk);
		#1 chk(pa_q_ff, 18'h0CAFE);
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		pa.go(1'b1, 1'b1, 13'h0008, 18'h0F00D);
		pa.idle();
		@(posedge mclk);
		#1 chk(pa_q_ff, 18'h0CAFE);
	endtask
	task automatic t_oreg();
		apb(1'b1, REG_CTRL, 32'h0000_0008);
		rdq(1'b0, 13'h0008, 18'h0CAFE, 1);
		@(posedge mclk);
		#1 chk(pa_q_ff, 18'h0F00D);
		@(posedge mclk);
		out_clr_n <= 1'b0;
		@(posedge mclk);
		#1 chk(32'(pa_q_ff), 32'h0000_0000);
		chk(32'(pb_q_ff), 32'h0000_0000);
		@(posedge mclk);
		out_clr_n <= 1'b1;
		apb(1'b1, REG_CTRL, 32'h0000_0000);
	endtask
	task automatic t_width();
		logic [31:0] cf[5] = '{32'h100, 32'h1100, 32'hA0, 32'h80, 32'h140};
		logic ce[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, REG_CTRL, cf[i]);
			apb(1'b0, REG_STATUS, 0);
			chk(rdat[S_CFG_ERR], ce[i]);
		end
		apb(1'b1, REG_CTRL, 32'h0000_1100);
		wr(1'b0, 13'h0003, 18'h3ABCD);
		rdq(1'b1, 13'h0003, 18'h3ABCD, 1);
		apb(1'b1, REG_CTRL, 32'h0000_0040);
		for (int n = 0; n < 4; n++)
			wr(1'b0, 13'(16 + n), 18'(9 + n));
		rdq(1'b1, 13'h0004, 18'h0CBA9, 1);
		rdq(1'b0, 13'h0011, 18'h0000A, 1);
	endtask
	task automatic t_rom();
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		apb(1'b1, REG_LOAD_ADDR, 32'h0000_0005);
		apb(1'b1, REG_LOAD_DATA, 32'h0000_1357);
		apb(1'b1, REG_CTRL, 32'h0000_0003);
		wr(1'b0, 13'h0005, 18'h0FFFF);
		rdq(1'b0, 13'h0005, 18'h01357, 1);
	endtask
	task automatic t_shift();
		// Zero both slots so no unknown word enters the taps
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, REG_LOAD_ADDR, 32'(s));
			apb(1'b1, REG_LOAD_DATA, 32'h0000_0000);
		end
		// Shift mode, tap spacing two
		apb(1'b1, REG_CTRL, 32'h0000_4001);
		for (int j = 0; j < 12; j++) begin
			@(posedge mclk);
			sr_en <= 1'b1;
			sr_in <= 4'(j + 1);
		end
		@(posedge mclk);
		sr_en <= 1'b0;
		@(posedge mclk);
		// Tap k holds the input from 2*(k+1) steps back
		#1 chk(32'(sr_taps_ff), 32'h0000_468A);
		chk(32'(sr_out_ff), 32'h0000_0004);
		apb(1'b1, REG_CTRL, 32'h0000_0000);
	endtask
	task automatic t_fifo();
		apb(1'b1, REG_CTRL, 32'h0000_0002);
		wr(1'b1, 13'h0000, 18'h11111);
		wr(1'b1, 13'h0000, 18'h22222);
		wr(1'b1, 13'h0000, 18'h33333);
		apb(1'b0, REG_STATUS, 0);
		chk(rdat, 32'h0000_0030);
		rdq(1'b0, 13'h0000, 18'h11111, 1);
		rdq(1'b0, 13'h0000, 18'h22222, 1);
		// Hold push until the last free word is taken
		pb.go(1'b1, 1'b0, 13'h0000, 18'h3FFFF);
		repeat (520) @(posedge mclk);
		pb.idle();
		#1 chk(32'(fifo_full_ff), 32'h0000_0001);
		apb(1'b0, REG_STATUS, 0);
		chk(rdat, 32'h0000_2008);
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		@(posedge mclk);
		#1 chk(32'(fe), 32'h0000_0001);
	endtask

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Clock at 40 MHz
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Watchdog cuts a hang short
	initial begin
		#200us;
		mismatches++;
		final_report();
	end
	// Main sequence
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		out_clr_n = 1'b1;
		sr_en = 1'b0;
		sr_in = 4'h0;
		repeat (3) @(posedge mclk);
		chk(32'(fe), 32'h0000_0001);
		chk(32'(pa_q_ff), 32'h0000_0000);
		chk(32'(pb_q_ff), 32'h0000_0000);
		arst_n <= 1'b1;
		t_regs();
		t_dual();
		t_rdw();
		t_oreg();
		t_width();
		t_rom();
		t_shift();
		t_fifo();
		final_report();
	end
endmodule

`default_nettype wire
